// File: hw/fwsr_consts.vh
`ifndef FWSR_CONSTS_VH
`define FWSR_CONSTS_VH
// clock and bus timing
`define FWSR_CLK_NS 20
`define FWSR_ACCESS_NS 70
`define FWSR_ACCESS_CYC ((`FWSR_ACCESS_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WE_NS 35
`define FWSR_WE_CYC ((`FWSR_WE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_RECOVER_CYC 4'h1
// controller register offsets
`define FWSR_OFS_CTRL 4'h0
`define FWSR_OFS_ADDR 4'h4
`define FWSR_OFS_DATA 4'h8
`define FWSR_OFS_STAT 4'hc
// control fields
`define FWSR_CTRL_GO 0
`define FWSR_CTRL_OP_LO 1
`define FWSR_CTRL_OP_HI 2
`define FWSR_CTRL_TOGGLE 3
`define FWSR_CTRL_HOLD 4
// operation codes
`define FWSR_OP_PROG 2'h0
`define FWSR_OP_ERASE 2'h1
`define FWSR_OP_POLL 2'h2
`define FWSR_OP_RESET 2'h3
// status fields
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_FAIL 2
`define FWSR_ST_RDY 3
`define FWSR_ST_SECTOG 4
`define FWSR_ST_DATA_LO 8
`define FWSR_ST_DATA_HI 15
// flash status bit positions on the data bus
`define FWSR_POLL_BIT 7
`define FWSR_GTOG_BIT 6
`define FWSR_FAIL_BIT 5
`define FWSR_STOG_BIT 2
// byte-mode command addresses and data
`define FWSR_UNLOCK_A1 21'h000aaa
`define FWSR_UNLOCK_A2 21'h000555
`define FWSR_UNLOCK_D1 8'haa
`define FWSR_UNLOCK_D2 8'h55
`define FWSR_CMD_PROG 8'ha0
`define FWSR_CMD_ERASE 8'h80
`define FWSR_CMD_SECTOR 8'h30
`define FWSR_CMD_RESET 8'hf0
`define FWSR_LEN_PROG 3'h4
`define FWSR_LEN_ERASE 3'h6
`define FWSR_LEN_RESET 3'h1
`endif

// File: hw/fwsr_cycle.v
`timescale 1ns/1ns
`include "fwsr_consts.vh"
// one asynchronous bus cycle (read or write) on the flash pins
module fwsr_cycle #(
	parameter AW = 21,
	parameter ACC = `FWSR_ACCESS_CYC,
	parameter WEW = `FWSR_WE_CYC
) (
	// clock, reset, enable
	input wire clk,
	input wire rst_n,
	input wire ce,
	// request side
	input wire start,
	input wire wr,
	input wire [AW-1:0] addr,
	input wire [7:0] wdata,
	output wire idle,
	output reg done,
	output reg [7:0] rdata,
	// flash pins
	output reg [AW-1:0] fl_addr,
	output reg [7:0] fl_dq_out,
	output reg fl_dq_oe,
	input wire [7:0] fl_dq_in,
	output reg fl_ce_n,
	output reg fl_oe_n,
	output reg fl_we_n
);
	localparam PH_IDLE = 2'h0; // pins parked
	localparam PH_STRB = 2'h1; // strobe low
	localparam PH_REC = 2'h2; // strobe high, recovery
	reg [1:0] ph_reg; // cycle phase
	reg [3:0] cnt_reg; // cycles left in phase
	reg wr_reg; // current cycle is a write

	assign idle = (ph_reg == PH_IDLE);

	// phase sequencer; each oe strobe falling-then-rising edge is one flash
	// read, which is what advances the toggle bits inside the device
	always @(posedge clk) begin
		if (!rst_n) begin
			ph_reg <= PH_IDLE;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			fl_addr <= {AW{1'b0}};
			fl_dq_out <= 8'h00;
			fl_dq_oe <= 1'b0;
			fl_ce_n <= 1'b1;
			fl_oe_n <= 1'b1;
			fl_we_n <= 1'b1;
		end else if (ce) begin
			done <= 1'b0;
			case (ph_reg)
				PH_IDLE: begin
					if (start) begin
						// address, data and chip enable with the strobe: one clock
						// of setup is traded away for a shorter cycle
						fl_addr <= addr;
						fl_dq_out <= wdata;
						fl_dq_oe <= wr;
						fl_ce_n <= 1'b0;
						fl_oe_n <= wr;
						fl_we_n <= ~wr;
						wr_reg <= wr;
						cnt_reg <= wr ? WEW[3:0] : ACC[3:0];
						ph_reg <= PH_STRB;
					end
				end
				PH_STRB: begin
					if (cnt_reg <= 4'h1) begin
						// sample just before the strobe rises; write data latch
						// on the rising we edge
						if (!wr_reg) begin
							rdata <= fl_dq_in;
						end
						fl_oe_n <= 1'b1;
						fl_we_n <= 1'b1;
						fl_ce_n <= 1'b1;
						cnt_reg <= `FWSR_RECOVER_CYC;
						ph_reg <= PH_REC;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				PH_REC: begin
					// keep data driven through the hold, then release the bus
					fl_dq_oe <= 1'b0;
					done <= 1'b1;
					ph_reg <= PH_IDLE;
				end
				default: begin
					ph_reg <= PH_IDLE;
				end
			endcase
		end
	end
endmodule

// File: hw/fwsr_host.v
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "fwsr_consts.vh"
// Overview of operation
// - read program address while polling
// - erase polling reads inside erased sector
// - take full byte on next read
// - two reads, compare toggles, next read data
// - toggling with fail bit: recheck, reset
// - returning from other work restarts procedure
// - reset command after fail bit seen
module fwsr_host #(
	parameter AW = 21
) (
	// clock, reset, enable
	input wire clk,
	input wire rst_n,
	input wire ce,
	// register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// flash pins
	output wire [AW-1:0] fl_addr,
	output wire [7:0] fl_dq_out,
	output wire fl_dq_oe,
	input wire [7:0] fl_dq_in,
	output wire fl_ce_n,
	output wire fl_oe_n,
	output wire fl_we_n,
	input wire ready_busy_out_n
);
	// controller states
	localparam S_IDLE = 4'h0; // waiting for go
	localparam S_CMD = 4'h1; // writing a command sequence
	localparam S_CRD = 4'h2; // complement polling read
	localparam S_CRE = 4'h3; // complement recheck after fail bit
	localparam S_FIN = 4'h4; // one more read for the full byte
	localparam S_TR1 = 4'h5; // first toggle read
	localparam S_TR2 = 4'h6; // following toggle read
	localparam S_HOLD = 4'h7; // polling left for other work
	localparam S_RST = 4'h8; // reset command after failure

	reg [3:0] state_reg; // controller state
	reg [2:0] idx_reg; // command write index
	reg [1:0] op_reg; // latched operation
	reg meth_reg; // 1: toggle polling, 0: complement polling
	reg hold_reg; // software asks polling to pause
	reg recheck_reg; // toggle pass is the recheck after fail bit
	reg [AW-1:0] addr_reg; // program address or sector address
	reg [7:0] data_reg; // program data
	reg [7:0] prev_reg; // previous status byte
	reg [7:0] last_reg; // last byte read
	reg done_reg; // sticky operation finished
	reg fail_reg; // sticky operation failed
	reg sectog_reg; // sector toggle seen in last compare
	reg rdy_reg; // sampled ready/busy line
	reg wait_reg; // a bus cycle is outstanding
	reg go_pulse; // go written this cycle
	wire cyc_idle;
	wire cyc_done;
	wire [7:0] cyc_rdata;
	reg cyc_start;
	reg cyc_wr;
	reg [AW-1:0] cyc_addr;
	reg [7:0] cyc_wdata;
	wire exp_bit; // true value expected on the polling bit
	wire poll_ok; // polling bit shows true data
	wire tog_same; // global toggle did not change between reads
	wire [2:0] seq_len;

	// command sequence lengths per operation
	function [2:0] fn_len;
		input [1:0] op;
		begin
			case (op)
				`FWSR_OP_PROG: fn_len = `FWSR_LEN_PROG;
				`FWSR_OP_ERASE: fn_len = `FWSR_LEN_ERASE;
				`FWSR_OP_RESET: fn_len = `FWSR_LEN_RESET;
				default: fn_len = 3'h0;
			endcase
		end
	endfunction

	// address of one write in a command sequence
	function [AW-1:0] fn_seq_addr;
		input [1:0] op;
		input [2:0] idx;
		input [AW-1:0] target;
		begin
			case (idx)
				3'h0: fn_seq_addr = (op == `FWSR_OP_RESET) ? {AW{1'b0}} : `FWSR_UNLOCK_A1;
				3'h1: fn_seq_addr = `FWSR_UNLOCK_A2;
				3'h2: fn_seq_addr = `FWSR_UNLOCK_A1;
				3'h3: fn_seq_addr = (op == `FWSR_OP_PROG) ? target : `FWSR_UNLOCK_A1;
				3'h4: fn_seq_addr = `FWSR_UNLOCK_A2;
				default: fn_seq_addr = target;
			endcase
		end
	endfunction

	// data of one write in a command sequence
	function [7:0] fn_seq_data;
		input [1:0] op;
		input [2:0] idx;
		input [7:0] pdata;
		begin
			case (idx)
				3'h0: fn_seq_data = (op == `FWSR_OP_RESET) ? `FWSR_CMD_RESET : `FWSR_UNLOCK_D1;
				3'h1: fn_seq_data = `FWSR_UNLOCK_D2;
				3'h2: fn_seq_data = (op == `FWSR_OP_PROG) ? `FWSR_CMD_PROG : `FWSR_CMD_ERASE;
				3'h3: fn_seq_data = (op == `FWSR_OP_PROG) ? pdata : `FWSR_UNLOCK_D1;
				3'h4: fn_seq_data = `FWSR_UNLOCK_D2;
				default: fn_seq_data = `FWSR_CMD_SECTOR;
			endcase
		end
	endfunction

	assign seq_len = fn_len(op_reg);
	// erase drives 0 then 1; program drives the inverse then the true bit
	assign exp_bit = (op_reg == `FWSR_OP_ERASE) ? 1'b1 : data_reg[`FWSR_POLL_BIT];
	assign poll_ok = (cyc_rdata[`FWSR_POLL_BIT] == exp_bit);
	// the device inverts the toggle after each read, so equal means stopped
	assign tog_same = (cyc_rdata[`FWSR_GTOG_BIT] == prev_reg[`FWSR_GTOG_BIT]);

	// bus cycle request; every poll read uses the target address, which is
	// the programmed location or a sector chosen for erasure
	always @* begin
		cyc_start = 1'b0;
		cyc_wr = 1'b0;
		cyc_addr = addr_reg;
		cyc_wdata = 8'h00;
		case (state_reg)
			S_CMD: begin
				// poll-only has no command writes; starting one here would leave a
				// write's done to be judged as a poll read
				cyc_start = cyc_idle && !wait_reg && (seq_len != 3'h0);
				cyc_wr = 1'b1;
				cyc_addr = fn_seq_addr(op_reg, idx_reg, addr_reg);
				cyc_wdata = fn_seq_data(op_reg, idx_reg, data_reg);
			end
			S_RST: begin
				cyc_start = cyc_idle && !wait_reg;
				cyc_wr = 1'b1;
				cyc_addr = {AW{1'b0}};
				cyc_wdata = `FWSR_CMD_RESET;
			end
			S_CRD, S_CRE, S_FIN, S_TR1, S_TR2: begin
				cyc_start = cyc_idle && !wait_reg;
			end
			default: begin
				cyc_start = 1'b0;
			end
		endcase
	end

	// go is only honoured from idle; a go during an operation is dropped
	always @* begin
		go_pulse = reg_wr && (reg_addr == `FWSR_OFS_CTRL) && reg_wdata[`FWSR_CTRL_GO];
	end

	// register writes, status flags and the polling sequencer
	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			idx_reg <= 3'h0;
			op_reg <= `FWSR_OP_PROG;
			meth_reg <= 1'b0;
			hold_reg <= 1'b0;
			recheck_reg <= 1'b0;
			addr_reg <= {AW{1'b0}};
			data_reg <= 8'h00;
			prev_reg <= 8'h00;
			last_reg <= 8'h00;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			sectog_reg <= 1'b0;
			rdy_reg <= 1'b1;
			wait_reg <= 1'b0;
		end else if (ce) begin
			// ready/busy is a wired line; it reads high only when all
			// devices on it have released it
			rdy_reg <= ready_busy_out_n;
			if (reg_wr && reg_addr == `FWSR_OFS_CTRL) begin
				hold_reg <= reg_wdata[`FWSR_CTRL_HOLD];
			end
			if (reg_wr && reg_addr == `FWSR_OFS_ADDR && state_reg == S_IDLE) begin
				addr_reg <= reg_wdata[AW-1:0];
			end
			if (reg_wr && reg_addr == `FWSR_OFS_DATA && state_reg == S_IDLE) begin
				data_reg <= reg_wdata[7:0];
			end
			// write one to clear; a set in the same cycle wins below
			if (reg_wr && reg_addr == `FWSR_OFS_STAT) begin
				if (reg_wdata[`FWSR_ST_DONE]) begin
					done_reg <= 1'b0;
				end
				if (reg_wdata[`FWSR_ST_FAIL]) begin
					fail_reg <= 1'b0;
				end
			end
			if (cyc_start) begin
				wait_reg <= 1'b1;
			end else if (cyc_done) begin
				wait_reg <= 1'b0;
			end
			if (cyc_done && !cyc_wr) begin
				last_reg <= cyc_rdata;
			end
			case (state_reg)
				S_IDLE: begin
					if (go_pulse) begin
						op_reg <= reg_wdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO];
						meth_reg <= reg_wdata[`FWSR_CTRL_TOGGLE];
						idx_reg <= 3'h0;
						recheck_reg <= 1'b0;
						state_reg <= S_CMD;
					end
				end
				S_CMD: begin
					// polling starts only after the last write strobe has risen
					if (cyc_done || seq_len == 3'h0) begin
						idx_reg <= idx_reg + 3'h1;
						if (seq_len == 3'h0 || idx_reg == seq_len - 3'h1) begin
							if (op_reg == `FWSR_OP_RESET) begin
								done_reg <= 1'b1;
								state_reg <= S_IDLE;
							end else begin
								state_reg <= meth_reg ? S_TR1 : S_CRD;
							end
						end
					end
				end
				S_CRD: begin
					if (cyc_done) begin
						if (poll_ok) begin
							state_reg <= S_FIN;
						end else if (cyc_rdata[`FWSR_FAIL_BIT]) begin
							state_reg <= S_CRE;
						end else if (hold_reg) begin
							state_reg <= S_HOLD;
						end
					end
				end
				S_CRE: begin
					// the polling bit may flip together with the fail bit
					if (cyc_done) begin
						state_reg <= poll_ok ? S_FIN : S_RST;
					end
				end
				S_FIN: begin
					if (cyc_done) begin
						done_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				S_TR1: begin
					if (cyc_done) begin
						prev_reg <= cyc_rdata;
						state_reg <= S_TR2;
					end
				end
				S_TR2: begin
					if (cyc_done) begin
						prev_reg <= cyc_rdata;
						// a sector toggle flag marks a sector chosen for erasure
						sectog_reg <= cyc_rdata[`FWSR_STOG_BIT] ^ prev_reg[`FWSR_STOG_BIT];
						if (tog_same) begin
							state_reg <= S_FIN;
						end else if (recheck_reg) begin
							state_reg <= S_RST;
						end else if (cyc_rdata[`FWSR_FAIL_BIT]) begin
							recheck_reg <= 1'b1;
							state_reg <= S_TR1;
						end else if (hold_reg) begin
							state_reg <= S_HOLD;
						end
					end
				end
				S_HOLD: begin
					// a fresh pair of reads is needed, so restart at the top
					if (!hold_reg) begin
						recheck_reg <= 1'b0;
						state_reg <= meth_reg ? S_TR1 : S_CRD;
					end
				end
				S_RST: begin
					if (cyc_done) begin
						fail_reg <= 1'b1;
						done_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// register read port, data valid the cycle after the strobe
	always @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (ce) begin
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					`FWSR_OFS_CTRL: begin
						reg_rdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO] <= op_reg;
						reg_rdata[`FWSR_CTRL_TOGGLE] <= meth_reg;
						reg_rdata[`FWSR_CTRL_HOLD] <= hold_reg;
					end
					`FWSR_OFS_ADDR: reg_rdata[AW-1:0] <= addr_reg;
					`FWSR_OFS_DATA: reg_rdata[7:0] <= data_reg;
					`FWSR_OFS_STAT: begin
						reg_rdata[`FWSR_ST_BUSY] <= (state_reg != S_IDLE);
						reg_rdata[`FWSR_ST_DONE] <= done_reg;
						reg_rdata[`FWSR_ST_FAIL] <= fail_reg;
						reg_rdata[`FWSR_ST_RDY] <= rdy_reg;
						reg_rdata[`FWSR_ST_SECTOG] <= sectog_reg;
						reg_rdata[`FWSR_ST_DATA_HI:`FWSR_ST_DATA_LO] <= last_reg;
					end
					default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// pin-level cycle engine; protected targets (brief activity, then array
	// data) need no special path: the poll simply sees true data
	fwsr_cycle #(
		.AW(AW)
	) u_cycle (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(cyc_start),
		.wr(cyc_wr),
		.addr(cyc_addr),
		.wdata(cyc_wdata),
		.idle(cyc_idle),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.fl_addr(fl_addr),
		.fl_dq_out(fl_dq_out),
		.fl_dq_oe(fl_dq_oe),
		.fl_dq_in(fl_dq_in),
		.fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n)
	);
endmodule

// File: dv/fwsr_flash_model.sv
`timescale 1ns/1ns
// behavioural flash: reports embedded program/erase status on its data pins
module fwsr_flash_model (
	// flash pins
	input wire [20:0] addr,
	input wire [7:0] dq_wr,
	output wire [7:0] dq_rd,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	output wire rb_low,
	// behaviour knobs set by the bench
	input wire [7:0] busy_len,
	input wire fail_mode
);
	reg [7:0] prev_reg = 8'h00; // last byte written, decodes the final write
	reg prog_reg = 1'b0; // embedded program running
	reg erase_reg = 1'b0; // embedded erase running
	reg fail_reg = 1'b0; // timeout fail flag
	reg gtog_reg = 1'b0; // global toggle state
	reg stog_reg = 1'b0; // sector toggle state
	reg [7:0] left_reg = 8'h00; // status reads left before completion
	reg [7:0] pd_reg = 8'hff; // programmed byte, ff once erased
	reg [7:0] last_reg = 8'h00; // last byte shown, inverted when released
	reg [7:0] f0_cnt = 8'h00; // reset commands seen
	reg [20:0] pa_reg = 21'h000000; // program or sector address
	wire rd_act = !ce_n && !oe_n;
	wire wr_act = !ce_n && !we_n;
	wire busy = prog_reg || erase_reg;
	wire in_sec = erase_reg && (addr[20:12] == pa_reg[20:12]);
	// status byte: complement bit, toggles, fail bit
	wire [7:0] stat = {prog_reg ? ~pd_reg[7] : 1'b0, gtog_reg, fail_reg, 2'b00,
		in_sec ? stog_reg : 1'b0, 2'b00};
	wire [7:0] cur = busy ? stat : ((addr == pa_reg) ? pd_reg : 8'hff);
	// released bus shows the inverse so a stale value never passes
	assign dq_rd = rd_act ? cur : ~last_reg;
	assign rb_low = busy; // open drain pull low while busy
	// end of a write: the final write edge starts the operation
	always @(negedge wr_act) begin
		if (prev_reg == 8'ha0) begin
			prog_reg = 1'b1;
			pa_reg = addr;
			pd_reg = dq_wr;
			left_reg = busy_len;
		end else if (dq_wr == 8'h30 && prev_reg == 8'h55) begin
			erase_reg = 1'b1;
			pa_reg = addr;
			pd_reg = 8'hff;
			left_reg = busy_len;
		end else if (dq_wr == 8'hf0) begin
			// reset command clears status and the fail flag
			prog_reg = 1'b0;
			erase_reg = 1'b0;
			fail_reg = 1'b0;
			f0_cnt = f0_cnt + 8'h01;
		end
		prev_reg = dq_wr;
	end
	// end of a read: toggles invert after each read while busy (the sector toggle only inside the sector)
	always @(negedge rd_act) begin
		last_reg = cur;
		if (busy) begin
			gtog_reg = ~gtog_reg;
			if (in_sec)
				stog_reg = ~stog_reg;
			if (left_reg != 8'h00)
				left_reg = left_reg - 8'h01;
			else if (fail_mode)
				fail_reg = 1'b1; // keeps toggling with the flag up
			else begin
				prog_reg = 1'b0;
				erase_reg = 1'b0;
			end
		end
	end
endmodule

// File: dv/fwsr_host_chk.sv
`timescale 1ns/1ns
// port-level checks on the polling controller
module fwsr_host_chk #(
	parameter AW = 21
) (
	// clock and control
	input wire clk,
	input wire rst_n,
	input wire ce,
	// register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// flash pins
	input wire [AW-1:0] fl_addr,
	input wire [7:0] fl_dq_out,
	input wire fl_dq_oe,
	input wire [7:0] fl_dq_in,
	input wire fl_ce_n,
	input wire fl_oe_n,
	input wire fl_we_n,
	input wire ready_busy_out_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// read access: strobes low four cycles, then released
	sequence seq_rd_low;
		(!fl_oe_n && !fl_ce_n && fl_we_n)[*4] ##1 fl_oe_n;
	endsequence
	// write access: two low cycles, data held into recovery
	sequence seq_we_low;
		(!fl_we_n && !fl_ce_n && fl_dq_oe)[*2] ##1 (fl_we_n && fl_dq_oe);
	endsequence
	chk_rd_cycle: assert property ($fell(fl_oe_n) |-> seq_rd_low)
		else $error("read access length wrong");
	chk_wr_cycle: assert property ($fell(fl_we_n) |-> seq_we_low)
		else $error("write access length wrong");
	chk_addr_hold: assert property ((!fl_oe_n && !$fell(fl_oe_n)) |-> $stable(fl_addr))
		else $error("address moved during read");
	chk_no_fight: assert property (!fl_oe_n |-> !fl_dq_oe)
		else $error("host drives data during read");
	chk_no_overlap: assert property (fl_oe_n || fl_we_n)
		else $error("read and write strobes together");
	chk_rdata_idle: assert property ((ce && !reg_rd) |=> reg_rdata == 32'h0)
		else $error("read data not cleared");
	chk_unmapped_zero: assert property (
		(ce && reg_rd && reg_addr[1:0] != 2'b00) |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_rdy_sample: assert property (
		(ce && reg_rd && reg_addr == 4'hc && $stable(ready_busy_out_n))
		|=> reg_rdata[3] == $past(ready_busy_out_n))
		else $error("ready bit not sampled");
endmodule
bind fwsr_host fwsr_host_chk #(.AW(AW)) u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
	.fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
	.ready_busy_out_n(ready_busy_out_n));

// File: dv/fwsr_host_tb.sv
`timescale 1ns/1ns
// register-level tests of the polling controller against the flash model
module fwsr_host_tb;
	reg clk, rst_n, ce, reg_wr, reg_rd, fail_mode;
	reg [3:0] reg_addr;
	reg [31:0] reg_wdata, rd_val;
	reg [7:0] busy_len, f0_before;
	wire [31:0] reg_rdata;
	wire [20:0] fl_addr;
	wire [7:0] fl_dq_out, fl_dq_in, dq_rd;
	wire fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, rb_low, rb_n;
	integer n_errors, checked, i;
	reg [7:0] ctl_t [0:3];
	reg [7:0] pd_t [0:3];
	reg [7:0] len_t [0:3];
	assign rb_n = rb_low ? 1'b0 : 1'b1; // pull-up on the shared line
	assign fl_dq_in = fl_dq_oe ? fl_dq_out : dq_rd; // wire level of the data bus
	fwsr_host #(.AW(21)) uut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
		.fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .ready_busy_out_n(rb_n));
	fwsr_flash_model u_flash (.addr(fl_addr), .dq_wr(fl_dq_in), .dq_rd(dq_rd), .ce_n(fl_ce_n),
		.oe_n(fl_oe_n), .we_n(fl_we_n), .rb_low(rb_low), .busy_len(busy_len),
		.fail_mode(fail_mode));
	task reg_write(input [3:0] a, input [31:0] d); begin
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	end endtask
	// read data stands only in the cycle after the strobe
	task reg_read(input [3:0] a, output [31:0] d); begin
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	end endtask
	task chk(input [31:0] got, input [31:0] exp, input [31:0] mask); begin
		checked = checked + 1;
		if ((got & mask) !== (exp & mask)) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	end endtask
	// poll status until busy drops, bounded
	task wait_done; begin
		for (i = 0; i < 3000; i = i + 1) begin
			reg_read(4'hc, rd_val);
			if (rd_val[0] === 1'b0)
				break;
		end
		if (i == 3000) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0t operation never finished", $time);
		end
	end endtask
	task run_op(input [7:0] ctl, input [20:0] a, input [7:0] d, input [7:0] n, input f); begin
		busy_len = n;
		fail_mode = f;
		reg_write(4'h4, {11'h000, a});
		reg_write(4'h8, {24'h0, d});
		reg_write(4'h0, {24'h0, ctl});
		wait_done;
	end endtask
	task give_verdict; begin
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// watchdog: the whole run needs well under 5000 cycles, allow 20000
	initial begin
		#400000;
		n_errors = n_errors + 1;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict;
	end
	initial begin
		n_errors = 0;
		checked = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		busy_len = 8'h00;
		fail_mode = 1'b0;
		// program/erase with both methods; lengths include the zero edge case
		ctl_t[0] = 8'h01; pd_t[0] = 8'h3c; len_t[0] = 8'h00;
		ctl_t[1] = 8'h09; pd_t[1] = 8'ha5; len_t[1] = 8'h01;
		ctl_t[2] = 8'h03; pd_t[2] = 8'hff; len_t[2] = 8'h07;
		ctl_t[3] = 8'h0b; pd_t[3] = 8'hff; len_t[3] = 8'h03;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		reg_read(4'hc, rd_val);
		chk(rd_val, 32'h8, 32'hffffffff);
		reg_read(4'h2, rd_val);
		chk(rd_val, 32'h0, 32'hffffffff);
		$display("reset and unmapped test done");
		for (int k = 0; k < 4; k = k + 1) begin
			run_op(ctl_t[k], (ctl_t[k][1]) ? 21'h01f000 : 21'h001234, pd_t[k], len_t[k], 1'b0);
			chk(rd_val, {16'h0, pd_t[k], 8'h0a}, 32'h0000ff0f);
			reg_write(4'hc, 32'h6);
		end
		$display("program and erase test done");
		for (int k = 0; k < 2; k = k + 1) begin
			f0_before = u_flash.f0_cnt;
			run_op(k ? 8'h01 : 8'h09, 21'h002000, 8'h0f, 8'h02, 1'b1);
			chk(rd_val, 32'he, 32'h0000000f);
			chk({24'h0, u_flash.f0_cnt}, {24'h0, f0_before + 8'h01}, 32'hff);
			reg_write(4'hc, 32'h6);
			reg_read(4'hc, rd_val);
			chk(rd_val, 32'h8, 32'h0000000f);
		end
		$display("failure test done");
		// hold parks the poller; the operation stays busy, so no wait_done here
		busy_len = 8'h14;
		fail_mode = 1'b0;
		reg_write(4'h4, 32'h00003456);
		reg_write(4'h8, 32'h0000005a);
		reg_write(4'h0, 32'h00000011);
		repeat (60) @(posedge clk);
		reg_read(4'hc, rd_val);
		chk(rd_val, 32'h1, 32'hb);
		chk({31'h0, rb_n}, 32'h0, 32'h1);
		// with ce low the hold release must be ignored
		ce <= 1'b0;
		reg_write(4'h0, 32'h0);
		ce <= 1'b1;
		// an address write while busy is refused
		reg_write(4'h4, 32'h0);
		reg_read(4'h0, rd_val);
		chk(rd_val, 32'h10, 32'h1f);
		reg_read(4'h4, rd_val);
		chk(rd_val, 32'h00003456, 32'hffffffff);
		reg_write(4'h0, 32'h0);
		wait_done;
		chk(rd_val, 32'h00005a0a, 32'h0000ff0f);
		reg_write(4'hc, 32'h6);
		$display("hold test done");
		f0_before = u_flash.f0_cnt;
		run_op(8'h07, 21'h000000, 8'h00, 8'h00, 1'b0);
		chk({24'h0, u_flash.f0_cnt}, {24'h0, f0_before + 8'h01}, 32'hff);
		chk(rd_val, 32'h0000000a, 32'h0000000f);
		reg_write(4'hc, 32'h6);
		$display("reset command test done");
		// poll only: no command writes, the first read already shows array data
		run_op(8'h05, 21'h003456, 8'h5a, 8'h00, 1'b0);
		chk(rd_val, 32'h00005a0a, 32'h0000ff0f);
		$display("poll only test done");
		give_verdict;
	end
endmodule
